// [hdl/csr_regs.svh]
/*
 * Register addresses, field positions, reset values and decode constants
 * for the charger setpoint register bank.
 * Assumes a byte-wide register port with 8-bit addresses.
 */
`ifndef CSR_REGS_SVH
`define CSR_REGS_SVH

// Register addresses on the serial register port
`define CSR_ADDR_PRECHG_TERM   8'h03
`define CSR_ADDR_CHG_VOLT      8'h04
`define CSR_ADDR_TERM_TIMER    8'h05
`define CSR_ADDR_BOOST_THERM   8'h06

// Reset values
`define CSR_RST_PRECHG_TERM    8'h11
`define CSR_RST_CHG_VOLT       8'hb2
`define CSR_RST_TERM_TIMER     8'h9c
`define CSR_RST_BOOST_THERM    8'h73

// Field positions, precharge and termination register
`define CSR_PRECHG_MSB         7
`define CSR_PRECHG_LSB         4
`define CSR_END_OF_CHARGE_CURRENT_CODE_MSB          2
`define CSR_END_OF_CHARGE_CURRENT_CODE_LSB          0

// Field positions, charge voltage register
`define CSR_CHARGE_VOLTAGE_CODE_MSB           7
`define CSR_CHARGE_VOLTAGE_CODE_LSB           2
`define CSR_LOWV_BIT           1
`define CSR_RECHG_BIT          0

// Field positions, termination and timer register
`define CSR_TERM_EN_BIT        7
`define CSR_WDOG_MSB           5
`define CSR_WDOG_LSB           4
`define CSR_TMR_EN_BIT         3
`define CSR_TMR_MSB            2
`define CSR_TMR_LSB            1

// Field positions, boost and thermal register
`define CSR_BOOST_VOLTAGE_CODE_MSB         7
`define CSR_BOOST_VOLTAGE_CODE_LSB         4
`define CSR_BHOT_MSB           3
`define CSR_BHOT_LSB           2
`define CSR_THERMAL_LIMIT_SEL_MSB           1
`define CSR_THERMAL_LIMIT_SEL_LSB           0

// Setpoint scale: current in mA, voltage in mV, time in s or hours
`define CSR_CUR_STEP_MA        12'd128
`define CSR_CHARGE_VOLTAGE_CODE_BASE_MV       13'd3504
`define CSR_CHARGE_VOLTAGE_CODE_STEP_MV       13'd16
`define CSR_CHARGE_VOLTAGE_CODE_MAX_MV        13'd4400
`define CSR_LOWV_LO_MV         13'd2800
`define CSR_LOWV_HI_MV         13'd3000
`define CSR_RECHG_LO_MV        9'd100
`define CSR_RECHG_HI_MV        9'd300
`define CSR_WDOG_BASE_S        8'd40
`define CSR_TMR_5H             5'd5
`define CSR_TMR_8H             5'd8
`define CSR_TMR_12H            5'd12
`define CSR_TMR_20H            5'd20

`endif

// [hdl/csr_pkg.sv]
/*
 * Types shared by the charger setpoint register bank.
 * Assumes csr_regs.svh supplies addresses and reset values.
 */
package csr_pkg;

	// Register selected by the port address
	typedef enum logic [2:0] {
		CSR_SEL_NONE,
		CSR_SEL_PRECHG_TERM,
		CSR_SEL_CHG_VOLT,
		CSR_SEL_TERM_TIMER,
		CSR_SEL_BOOST_THERM
	} csr_sel_t;

	// Fast charge safety period choice
	typedef enum logic [1:0] {
		CSR_TMR_5_HRS,
		CSR_TMR_8_HRS,
		CSR_TMR_12_HRS,
		CSR_TMR_20_HRS
	} csr_tmr_t;

endpackage : csr_pkg

// [hdl/csr_decode.sv]
/*
 * Turns stored register codes into setpoints in mA, mV, s and hours.
 * Assumes codes come straight from the register flops; output is
 * combinational and the parent registers whatever it exposes.
 */
`timescale 1ns/1ps
`include "csr_regs.svh"

module csr_decode
	import csr_pkg::*;
(
	input  wire logic [3:0]  precharge_current_code,
	input  wire logic [2:0]  end_of_charge_current_code,
	input  wire logic [5:0]  charge_voltage_code,
	input  wire logic        precharge_exit_threshold,
	input  wire logic        recharge_offset_sel,
	input  wire logic [1:0]  watchdog_code,
	input  wire logic [1:0]  fast_charge_time_sel,
	output logic      [11:0] precharge_ma,
	output logic      [11:0] term_ma,
	output logic      [12:0] charge_voltage_code_mv,
	output logic             charge_voltage_code_over_range,
	output logic      [12:0] lowv_mv,
	output logic      [8:0]  rechg_mv,
	output logic      [7:0]  watchdog_s,
	output logic      [4:0]  safety_hours
);

	// Codes 0 and 1 both give one current step; from 0101 up the scale
	// skips one step, so code 1111 lands on 2048 mA
	always_comb begin
		if (precharge_current_code == 4'h0) begin
			precharge_ma = `CSR_CUR_STEP_MA;
		end else if (precharge_current_code <= 4'h4) begin
			precharge_ma = 12'(precharge_current_code) * `CSR_CUR_STEP_MA;
		end else begin
			precharge_ma = 12'({1'b0, precharge_current_code} + 5'h01)
				* `CSR_CUR_STEP_MA;
		end
	end

	// Termination current is base plus binary weights
	assign term_ma = 12'(({1'b0, end_of_charge_current_code} + 4'h1))
		* `CSR_CUR_STEP_MA;

	// Charge voltage and its usable range
	assign charge_voltage_code_mv = `CSR_CHARGE_VOLTAGE_CODE_BASE_MV
		+ 13'(charge_voltage_code) * `CSR_CHARGE_VOLTAGE_CODE_STEP_MV;
	assign charge_voltage_code_over_range = charge_voltage_code_mv > `CSR_CHARGE_VOLTAGE_CODE_MAX_MV;

	// Precharge exit and recharge offset selects
	assign lowv_mv  = precharge_exit_threshold ? `CSR_LOWV_HI_MV
		: `CSR_LOWV_LO_MV;
	assign rechg_mv = recharge_offset_sel ? `CSR_RECHG_HI_MV
		: `CSR_RECHG_LO_MV;

	// Watchdog period doubles per code, zero disables
	always_comb begin
		case (watchdog_code)
			2'h1:    watchdog_s = `CSR_WDOG_BASE_S;
			2'h2:    watchdog_s = `CSR_WDOG_BASE_S << 1;
			2'h3:    watchdog_s = `CSR_WDOG_BASE_S << 2;
			default: watchdog_s = 8'h00;
		endcase
	end

	// Safety period table
	always_comb begin
		case (csr_tmr_t'(fast_charge_time_sel))
			CSR_TMR_5_HRS:  safety_hours = `CSR_TMR_5H;
			CSR_TMR_8_HRS:  safety_hours = `CSR_TMR_8H;
			CSR_TMR_12_HRS: safety_hours = `CSR_TMR_12H;
			CSR_TMR_20_HRS: safety_hours = `CSR_TMR_20H;
			default:        safety_hours = `CSR_TMR_12H;
		endcase
	end

endmodule : csr_decode

// [hdl/csr_bank.sv]
/*
 * Charger setpoint register bank: four byte-wide read/write registers
 * reached through the device's serial register port, plus decoded
 * setpoints for the regulation loops.
 * Assumes the serial port front end delivers a one-cycle write strobe
 * with address and data, and reads combinationally by address.
 */
`timescale 1ns/1ps
`include "csr_regs.svh"

module csr_bank
	import csr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	output logic             reg_hit,
	output logic      [3:0]  precharge_current_code,
	output logic      [2:0]  end_of_charge_current_code,
	output logic      [5:0]  charge_voltage_code,
	output logic             precharge_exit_threshold,
	output logic             recharge_offset_sel,
	output logic             term_enable,
	output logic      [1:0]  watchdog_code,
	output logic             safety_timer_enable,
	output logic      [1:0]  fast_charge_time_sel,
	output logic      [3:0]  boost_voltage_code,
	output logic      [1:0]  boost_hot_sel,
	output logic      [1:0]  thermal_limit_sel,
	output logic      [11:0] precharge_ma,
	output logic      [11:0] term_ma,
	output logic      [12:0] charge_voltage_code_mv,
	output logic             charge_voltage_code_over_range,
	output logic      [12:0] lowv_mv,
	output logic      [8:0]  rechg_mv,
	output logic      [7:0]  watchdog_s,
	output logic      [4:0]  safety_hours
);

	logic [7:0] precharge_term_current_reg;
	logic [7:0] charge_voltage_ctrl_reg;
	logic [7:0] termination_timer_ctrl_reg;
	logic [7:0] boost_thermal_ctrl_reg;
	csr_sel_t   sel;

	logic [11:0] precharge_ma_next;
	logic [11:0] term_ma_next;
	logic [12:0] charge_voltage_code_mv_next;
	logic        charge_voltage_code_over_next;
	logic [12:0] lowv_mv_next;
	logic [8:0]  rechg_mv_next;
	logic [7:0]  watchdog_s_next;
	logic [4:0]  safety_hours_next;

	// Address to register select, used by write and read alike
	function automatic csr_sel_t csr_addr_sel(input logic [7:0] a);
		case (a)
			`CSR_ADDR_PRECHG_TERM: csr_addr_sel = CSR_SEL_PRECHG_TERM;
			`CSR_ADDR_CHG_VOLT:    csr_addr_sel = CSR_SEL_CHG_VOLT;
			`CSR_ADDR_TERM_TIMER:  csr_addr_sel = CSR_SEL_TERM_TIMER;
			`CSR_ADDR_BOOST_THERM: csr_addr_sel = CSR_SEL_BOOST_THERM;
			default:               csr_addr_sel = CSR_SEL_NONE;
		endcase
	endfunction : csr_addr_sel

	assign sel     = csr_addr_sel(reg_addr);
	assign reg_hit = (sel != CSR_SEL_NONE);

	// Precharge and termination register; reserved bit 3 is stored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			precharge_term_current_reg <= `CSR_RST_PRECHG_TERM;
		end else if (reg_wr && sel == CSR_SEL_PRECHG_TERM) begin
			precharge_term_current_reg <= reg_wdata;
		end
	end

	// Charge voltage register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			charge_voltage_ctrl_reg <= `CSR_RST_CHG_VOLT;
		end else if (reg_wr && sel == CSR_SEL_CHG_VOLT) begin
			charge_voltage_ctrl_reg <= reg_wdata;
		end
	end

	// Termination and timer register; reserved bits 6 and 0 are stored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			termination_timer_ctrl_reg <= `CSR_RST_TERM_TIMER;
		end else if (reg_wr && sel == CSR_SEL_TERM_TIMER) begin
			termination_timer_ctrl_reg <= reg_wdata;
		end
	end

	// Boost and thermal register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			boost_thermal_ctrl_reg <= `CSR_RST_BOOST_THERM;
		end else if (reg_wr && sel == CSR_SEL_BOOST_THERM) begin
			boost_thermal_ctrl_reg <= reg_wdata;
		end
	end

	// Read back, whole byte including reserved bits; unmapped reads zero
	always_comb begin
		case (sel)
			CSR_SEL_PRECHG_TERM: reg_rdata = precharge_term_current_reg;
			CSR_SEL_CHG_VOLT:    reg_rdata = charge_voltage_ctrl_reg;
			CSR_SEL_TERM_TIMER:  reg_rdata = termination_timer_ctrl_reg;
			CSR_SEL_BOOST_THERM: reg_rdata = boost_thermal_ctrl_reg;
			default:             reg_rdata = 8'h00;
		endcase
	end

	// Field views of the stored codes (reset codes follow the bytes)
	assign precharge_current_code = precharge_term_current_reg
		[`CSR_PRECHG_MSB:`CSR_PRECHG_LSB];
	assign end_of_charge_current_code = precharge_term_current_reg
		[`CSR_END_OF_CHARGE_CURRENT_CODE_MSB:`CSR_END_OF_CHARGE_CURRENT_CODE_LSB];
	assign charge_voltage_code = charge_voltage_ctrl_reg
		[`CSR_CHARGE_VOLTAGE_CODE_MSB:`CSR_CHARGE_VOLTAGE_CODE_LSB];
	assign precharge_exit_threshold =
		charge_voltage_ctrl_reg[`CSR_LOWV_BIT];
	assign recharge_offset_sel =
		charge_voltage_ctrl_reg[`CSR_RECHG_BIT];
	assign term_enable =
		termination_timer_ctrl_reg[`CSR_TERM_EN_BIT];
	assign watchdog_code = termination_timer_ctrl_reg
		[`CSR_WDOG_MSB:`CSR_WDOG_LSB];
	assign safety_timer_enable =
		termination_timer_ctrl_reg[`CSR_TMR_EN_BIT];
	assign fast_charge_time_sel = termination_timer_ctrl_reg
		[`CSR_TMR_MSB:`CSR_TMR_LSB];
	assign boost_voltage_code = boost_thermal_ctrl_reg
		[`CSR_BOOST_VOLTAGE_CODE_MSB:`CSR_BOOST_VOLTAGE_CODE_LSB];
	assign boost_hot_sel = boost_thermal_ctrl_reg
		[`CSR_BHOT_MSB:`CSR_BHOT_LSB];
	assign thermal_limit_sel = boost_thermal_ctrl_reg
		[`CSR_THERMAL_LIMIT_SEL_MSB:`CSR_THERMAL_LIMIT_SEL_LSB];

	// Setpoint decode from the stored codes
	csr_decode u_decode (
		.precharge_current_code     (precharge_current_code),
		.end_of_charge_current_code (end_of_charge_current_code),
		.charge_voltage_code        (charge_voltage_code),
		.precharge_exit_threshold   (precharge_exit_threshold),
		.recharge_offset_sel        (recharge_offset_sel),
		.watchdog_code              (watchdog_code),
		.fast_charge_time_sel       (fast_charge_time_sel),
		.precharge_ma               (precharge_ma_next),
		.term_ma                    (term_ma_next),
		.charge_voltage_code_mv                    (charge_voltage_code_mv_next),
		.charge_voltage_code_over_range            (charge_voltage_code_over_next),
		.lowv_mv                    (lowv_mv_next),
		.rechg_mv                   (rechg_mv_next),
		.watchdog_s                 (watchdog_s_next),
		.safety_hours               (safety_hours_next)
	);

	// Setpoints registered so loops see glitch-free values; reset matches
	// the decode of the reset bytes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			precharge_ma    <= 12'd128;
			term_ma         <= 12'd256;
			charge_voltage_code_mv         <= 13'd4208;
			charge_voltage_code_over_range <= 1'b0;
			lowv_mv         <= `CSR_LOWV_HI_MV;
			rechg_mv        <= `CSR_RECHG_LO_MV;
			watchdog_s      <= `CSR_WDOG_BASE_S;
			safety_hours    <= `CSR_TMR_12H;
		end else begin
			precharge_ma    <= precharge_ma_next;
			term_ma         <= term_ma_next;
			charge_voltage_code_mv         <= charge_voltage_code_mv_next;
			charge_voltage_code_over_range <= charge_voltage_code_over_next;
			lowv_mv         <= lowv_mv_next;
			rechg_mv        <= rechg_mv_next;
			watchdog_s      <= watchdog_s_next;
			safety_hours    <= safety_hours_next;
		end
	end

endmodule : csr_bank

// [dv/csr_host_model.sv]
/* Host side of the register port: byte writes and combinational reads.
   Assumes the bench calls its tasks and ends each write, or run of back-to-back writes, with idle. */
`timescale 1ns/1ps
`include "csr_regs.svh"

module csr_host_model (
	input  wire logic       clk,
	output logic            reg_wr,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	// Quiet port at time zero
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end

	// One byte per call; reserved bits go out as zero unless raw
	task automatic wr(input logic [7:0] a, d, input logic raw);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = raw ? d : d & ((a == `CSR_ADDR_PRECHG_TERM) ? 8'hf7 :
			(a == `CSR_ADDR_TERM_TIMER) ? 8'hbe : 8'hff);
	endtask : wr

	// Drops the strobe; data lines no longer show the written byte
	task automatic idle();
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~reg_wdata;
	endtask : idle

	// Read data is combinational, taken once the address has settled
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		#1 d = reg_rdata;
	endtask : rd
endmodule : csr_host_model

// [dv/csr_bank_sva.sv]
/* Port checker for the setpoint register bank.
   Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps

module csr_bank_sva (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic [3:0]  precharge_current_code,
	input wire logic [2:0]  end_of_charge_current_code,
	input wire logic [5:0]  charge_voltage_code,
	input wire logic        precharge_exit_threshold,
	input wire logic        recharge_offset_sel,
	input wire logic        term_enable,
	input wire logic [1:0]  watchdog_code,
	input wire logic [11:0] term_ma,
	input wire logic [12:0] charge_voltage_code_mv,
	input wire logic        charge_voltage_code_over_range,
	input wire logic [12:0] lowv_mv,
	input wire logic [7:0]  watchdog_s
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_volt_write: assert property (reg_wr && reg_addr == 8'h04 |=>
		{charge_voltage_code, precharge_exit_threshold,
		recharge_offset_sel} == $past(reg_wdata))
		else $error("charge voltage fields not written");
	chk_timer_write: assert property (reg_wr && reg_addr == 8'h05 |=>
		{term_enable, watchdog_code} == {$past(reg_wdata[7]),
		$past(reg_wdata[5:4])})
		else $error("termination fields not written");
	chk_rsv_readback: assert property (reg_wr && reg_addr == 8'h03 ##1
		reg_addr == 8'h03 |-> reg_rdata == $past(reg_wdata))
		else $error("precharge byte not read back whole");
	chk_prechg_layout: assert property (reg_addr == 8'h03 |->
		reg_rdata[7:4] == precharge_current_code &&
		reg_rdata[2:0] == end_of_charge_current_code)
		else $error("precharge byte layout wrong");
	chk_charge_voltage_code_scale: assert property (charge_voltage_code_mv ==
		13'(3504 + 16 * $past(charge_voltage_code)))
		else $error("charge voltage scale wrong");
	chk_over_range: assert property (charge_voltage_code_over_range ==
		($past(charge_voltage_code) > 6'd56))
		else $error("over range flag wrong");
	chk_lowv_sel: assert property (lowv_mv ==
		($past(precharge_exit_threshold) ? 13'd3000 : 13'd2800))
		else $error("precharge exit threshold wrong");
	chk_term_scale: assert property (term_ma ==
		12'(128 + 128 * $past(end_of_charge_current_code)))
		else $error("termination current wrong");
	chk_wdog_period: assert property (watchdog_s ==
		($past(watchdog_code) == 2'b00 ? 8'd0 :
		8'(20 << $past(watchdog_code))))
		else $error("watchdog period wrong");
endmodule : csr_bank_sva

bind csr_bank csr_bank_sva chk_u (.*);

// [dv/charger_setpoint_registers_tb.sv]
/* Bench for the setpoint register bank: table of writes, then resets
   and decode cases. Assumes the host model drives the port. */
`timescale 1ns/1ps
`include "csr_regs.svh"

module charger_setpoint_registers_tb;
	logic        clk, resetn, reg_wr, reg_hit, charge_voltage_code_over_range, en;
	logic        precharge_exit_threshold, recharge_offset_sel;
	logic        term_enable, safety_timer_enable;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, watchdog_s, got;
	logic [3:0]  precharge_current_code, boost_voltage_code;
	logic [2:0]  end_of_charge_current_code;
	logic [5:0]  charge_voltage_code;
	logic [1:0]  watchdog_code, fast_charge_time_sel, boost_hot_sel;
	logic [1:0]  thermal_limit_sel;
	logic [11:0] precharge_ma, term_ma;
	logic [12:0] charge_voltage_code_mv, lowv_mv;
	logic [8:0]  rechg_mv;
	logic [4:0]  safety_hours;
	int          error_cnt, samples_checked, cycles;
	// Address, write data, expected read-back
	localparam logic [23:0] ROWS [6] = '{24'h03ffff, 24'h040000,
		24'h05ffff, 24'h06a5a5, 24'h075500, 24'h02aa00};
	localparam logic [7:0] RST [4] = '{`CSR_RST_PRECHG_TERM,
		`CSR_RST_CHG_VOLT, `CSR_RST_TERM_TIMER, `CSR_RST_BOOST_THERM};
	localparam logic [3:0] PC [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5,
		4'hf};
	localparam logic [11:0] PMA [6] = '{12'h080, 12'h080, 12'h100,
		12'h180, 12'h300, 12'h800};
	localparam logic [7:0] WDS [4] = '{8'h00, 8'h28, 8'h50, 8'ha0};
	localparam logic [4:0] HRS [4] = '{5'h05, 5'h08, 5'h0c, 5'h14};

	csr_bank dut_u (.*);
	csr_host_model host_u (.*);

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string nm, input logic [39:0] e, g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic finish_test();
		$display("compares %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	// Cuts a hung run short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			error_cnt++;
			finish_test();
		end
	end

	// Main sequence
	initial begin
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		foreach (ROWS[i]) begin
			host_u.wr(ROWS[i][23:16], ROWS[i][15:8], 1'b1);
			host_u.idle();
			host_u.rd(ROWS[i][23:16], got);
			check("rdback", ROWS[i][7:0], got);
			check("hit", ROWS[i][23:16] inside {[8'h03:8'h06]},
				reg_hit);
		end
		check("boost", {4'ha, 2'h1, 2'h1}, {boost_voltage_code,
			boost_hot_sel, thermal_limit_sel});
		// Reset in mid-run restores every default
		@(negedge clk);
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		for (int i = 0; i < 4; i++) begin
			host_u.rd(8'(`CSR_ADDR_PRECHG_TERM + i), got);
			check("rstval", RST[i], got);
		end
		check("rst_cur", {12'd128, 12'd256}, {precharge_ma, term_ma});
		check("rst_volt", {13'd4208, 1'b0, 13'd3000},
			{charge_voltage_code_mv, charge_voltage_code_over_range, lowv_mv});
		check("rst_misc", {9'd100, 8'd40, 5'd12, 2'b11},
			{rechg_mv, watchdog_s, safety_hours, term_enable,
			safety_timer_enable});
		check("rst_code", {4'h1, 3'h1, 6'h2c, 2'h1,
			2'h2, 4'h7, 2'h0, 2'h3}, {precharge_current_code,
			end_of_charge_current_code, charge_voltage_code,
			watchdog_code, fast_charge_time_sel, boost_voltage_code,
			boost_hot_sel, thermal_limit_sel});
		// Current codes, boundaries of both fields
		foreach (PC[i]) begin
			host_u.wr(`CSR_ADDR_PRECHG_TERM, {PC[i], 1'b0, PC[i][2:0]}, 1'b0);
			host_u.idle();
			@(negedge clk);
			check("current", {PMA[i], 12'(128 + 128 * PC[i][2:0])},
				{precharge_ma, term_ma});
		end
		// Every watchdog and timer code, enables cleared on code zero
		for (int i = 0; i < 4; i++) begin
			en = (i != 0);
			host_u.wr(`CSR_ADDR_TERM_TIMER, {en, 1'b0, 2'(i), en, 2'(i),
				1'b0}, 1'b0);
			host_u.idle();
			@(negedge clk);
			check("timer", {WDS[i], HRS[i], en, en},
				{watchdog_s, safety_hours, term_enable,
				safety_timer_enable});
		end
		// Back-to-back writes across the top of the voltage range
		host_u.wr(`CSR_ADDR_CHG_VOLT, 8'he0, 1'b0);
		host_u.wr(`CSR_ADDR_CHG_VOLT, 8'he7, 1'b0);
		host_u.idle();
		@(negedge clk);
		check("v57", {13'd4416, 1'b1, 13'd3000, 9'd300},
			{charge_voltage_code_mv, charge_voltage_code_over_range, lowv_mv, rechg_mv});
		host_u.wr(`CSR_ADDR_CHG_VOLT, 8'he0, 1'b0);
		host_u.idle();
		@(negedge clk);
		check("v56", {13'd4400, 1'b0, 13'd2800, 9'd100},
			{charge_voltage_code_mv, charge_voltage_code_over_range, lowv_mv, rechg_mv});
		finish_test();
	end
endmodule : charger_setpoint_registers_tb
